// [hw/bdpp_pkg.sv]
// package: constants, types and register map of the bridge power policy block
//
// Notes on behaviour
// - in the deepest off state the card-side bus clock stays stopped.
// - in the deepest off state card reset and card clock outputs are held low.
// - in the deepest off state no interrupt is raised on either bus.
// - deepest off keeps only wake context, only with wake enable; wake signalling likewise.
// - card removal detection keeps working in the deepest off state.
// - slot supply setting never changes in low power states except on card removal.
// - card removal switches the slot supply off in any power state.
// - in the deepest off state every host bus cycle is ignored.
// - retained wake context holds the event mask and event status registers.
`default_nettype none

package bdpp_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BDPP_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] BDPP_STATE_ADDR  = 8'h04;
  localparam logic [7:0] BDPP_EVSTS_ADDR  = 8'h08;
  localparam logic [7:0] BDPP_EVCLR_ADDR  = 8'h0c;
  localparam logic [7:0] BDPP_EVMASK_ADDR = 8'h10;

  // ---------------------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------------------
  localparam int BDPP_EV_W        = 3;
  localparam int BDPP_EV_REMOVE   = 0;
  localparam int BDPP_EV_INSERT   = 1;
  localparam int BDPP_EV_CARDWAKE = 2;

  // power state codes as seen by software
  localparam logic [1:0] BDPP_PS_D0 = 2'h0;
  localparam logic [1:0] BDPP_PS_D1 = 2'h1;
  localparam logic [1:0] BDPP_PS_D2 = 2'h2;
  localparam logic [1:0] BDPP_PS_D3 = 2'h3;

  // slot supply code for "off"
  localparam logic [1:0] BDPP_VCC_OFF = 2'h0;

  // control register: [0] card reset release, [2:1] slot vcc, [8] wake enable,
  // [17:16] requested power state
  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic [1:0]  power_state;
    logic [6:0]  rsvd_mid;
    logic        wake_en;
    logic [4:0]  rsvd_lo;
    logic [1:0]  slot_vcc;
    logic        card_rst_rel;
  } bdpp_ctrl_t;

  localparam bdpp_ctrl_t BDPP_CTRL_RST = '0;
  localparam logic [BDPP_EV_W-1:0] BDPP_EV_RST = 3'h0;

  // internal power states
  typedef enum logic [2:0] {
    BDPP_ST_D0_UNINIT = 3'b000,
    BDPP_ST_D0_ACTIVE = 3'b001,
    BDPP_ST_D1        = 3'b010,
    BDPP_ST_D2        = 3'b011,
    BDPP_ST_D3_HOT    = 3'b100,
    BDPP_ST_D3_COLD   = 3'b101
  } bdpp_state_t;

  // card side outputs travel together
  typedef struct packed {
    logic       clock;
    logic       reset_n;
    logic [1:0] slot_vcc;
  } bdpp_card_t;

endpackage : bdpp_pkg

`default_nettype wire

// [hw/bdpp_top.sv]
// module: bridge deepest-off power policy with apb register access
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module bdpp_top
  import bdpp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // host side power events
  input  wire logic        bus_seg_reset,
  input  wire logic        main_power_lost,
  // card side
  input  wire logic        card_present,
  input  wire logic        card_wake,
  input  wire logic        card_low_power,
  output bdpp_card_t       card,
  // wake and interrupt
  output logic             wake_n_o,
  output logic             wake_n_oe,
  output logic             irq
);

  // ---------------------------------------------------------------------------
  // state and register storage
  // ---------------------------------------------------------------------------
  bdpp_state_t            state_ff;
  bdpp_state_t            nxt_state;
  bdpp_ctrl_t             ctrl_ff;
  bdpp_ctrl_t             nxt_ctrl;
  logic [BDPP_EV_W-1:0]   evsts_ff;
  logic [BDPP_EV_W-1:0]   nxt_evsts;
  logic [BDPP_EV_W-1:0]   evmask_ff;
  logic [BDPP_EV_W-1:0]   nxt_evmask;
  logic                   present_ff;
  logic                   wake_in_ff;
  logic                   clk_div_ff;
  logic [31:0]            prdata_ff;
  logic [31:0]            nxt_prdata;
  logic                   err_ff;
  logic                   nxt_err;

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  // register hit test shared by read and write decoding
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire logic is_cold   = (state_ff == BDPP_ST_D3_COLD);
  wire logic setup     = psel && !penable;
  wire logic access    = psel && penable;
  wire logic mapped    = hit(paddr, BDPP_CTRL_ADDR) ||
                         hit(paddr, BDPP_STATE_ADDR) ||
                         hit(paddr, BDPP_EVSTS_ADDR) ||
                         hit(paddr, BDPP_EVCLR_ADDR) ||
                         hit(paddr, BDPP_EVMASK_ADDR);
  // in deepest off the host bus is dead: writes and reads have no effect
  wire logic wr_ok     = access && pwrite && mapped && !is_cold;
  wire logic wr_ctrl   = wr_ok && hit(paddr, BDPP_CTRL_ADDR);
  wire logic wr_evclr  = wr_ok && hit(paddr, BDPP_EVCLR_ADDR);
  wire logic wr_evmask = wr_ok && hit(paddr, BDPP_EVMASK_ADDR);

  // slave always answers in the first access cycle
  assign pready  = access;
  assign prdata  = prdata_ff;
  assign pslverr = access && err_ff;

  // ---------------------------------------------------------------------------
  // read data captured in the setup cycle
  // ---------------------------------------------------------------------------
  // registering the data keeps prdata glitch free without adding a wait cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_err    = err_ff;
    if (setup) begin
      nxt_err    = !mapped;
      nxt_prdata = 32'h0000_0000;
      if (is_cold) begin
        nxt_prdata = 32'h0000_0000;
      end else if (!pwrite) begin
        if (hit(paddr, BDPP_CTRL_ADDR)) begin
          nxt_prdata = ctrl_ff;
        end else if (hit(paddr, BDPP_STATE_ADDR)) begin
          nxt_prdata = {26'h0, present_ff, card.slot_vcc != BDPP_VCC_OFF,
                        1'b0, state_ff};
        end else if (hit(paddr, BDPP_EVSTS_ADDR)) begin
          nxt_prdata = {29'h0, evsts_ff};
        end else if (hit(paddr, BDPP_EVMASK_ADDR)) begin
          nxt_prdata = {29'h0, evmask_ff};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      err_ff    <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      err_ff    <= nxt_err;
    end
  end

  // ---------------------------------------------------------------------------
  // card event detection
  // ---------------------------------------------------------------------------
  // detection runs from always-on logic, so it works in every state
  wire logic ev_remove = present_ff && !card_present;
  wire logic ev_insert = !present_ff && card_present;
  wire logic ev_wake   = !wake_in_ff && card_wake && present_ff;
  wire logic [BDPP_EV_W-1:0] ev_now = {ev_wake, ev_insert, ev_remove};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_ff <= 1'b0;
      wake_in_ff <= 1'b0;
    end else begin
      present_ff <= card_present;
      wake_in_ff <= card_wake;
    end
  end

  // ---------------------------------------------------------------------------
  // power state sequencing
  // ---------------------------------------------------------------------------
  // deepest off is left only by bus segment reset; software cannot leave it
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BDPP_ST_D3_COLD: begin
        if (bus_seg_reset) begin
          nxt_state = BDPP_ST_D0_UNINIT;
        end
      end
      BDPP_ST_D3_HOT: begin
        if (bus_seg_reset) begin
          nxt_state = BDPP_ST_D0_UNINIT;
        end else if (main_power_lost &&
                     (card_low_power || !present_ff ||
                      ctrl_ff.slot_vcc == BDPP_VCC_OFF)) begin
          // card must already be asleep or unpowered before deepest off
          nxt_state = BDPP_ST_D3_COLD;
        end else if (wr_ctrl &&
                     pwdata[17:16] == BDPP_PS_D0) begin
          nxt_state = BDPP_ST_D0_UNINIT;
        end
      end
      BDPP_ST_D0_UNINIT, BDPP_ST_D0_ACTIVE, BDPP_ST_D1, BDPP_ST_D2: begin
        if (bus_seg_reset) begin
          nxt_state = BDPP_ST_D0_UNINIT;
        end else if (wr_ctrl) begin
          case (pwdata[17:16])
            BDPP_PS_D0: nxt_state = BDPP_ST_D0_ACTIVE;
            BDPP_PS_D1: nxt_state = BDPP_ST_D1;
            BDPP_PS_D2: nxt_state = BDPP_ST_D2;
            default:    nxt_state = BDPP_ST_D3_HOT;
          endcase
        end
      end
      default: nxt_state = BDPP_ST_D0_UNINIT;
    endcase
  end

  // ---------------------------------------------------------------------------
  // control register and slot supply
  // ---------------------------------------------------------------------------
  // slot vcc may be set by software only in D0 (uninitialised or full-on); removal always cuts it
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl.card_rst_rel = pwdata[0];
      nxt_ctrl.wake_en      = pwdata[8];
      nxt_ctrl.power_state  = pwdata[17:16];
      if (state_ff == BDPP_ST_D0_ACTIVE ||
          state_ff == BDPP_ST_D0_UNINIT) begin
        nxt_ctrl.slot_vcc = pwdata[2:1];
      end
    end
    if (nxt_state == BDPP_ST_D0_UNINIT && state_ff == BDPP_ST_D3_COLD) begin
      nxt_ctrl.power_state  = BDPP_PS_D0;
      nxt_ctrl.card_rst_rel = 1'b0;
    end
    if (ev_remove) begin
      nxt_ctrl.slot_vcc = BDPP_VCC_OFF;
    end
    nxt_ctrl.rsvd_hi  = '0;
    nxt_ctrl.rsvd_mid = '0;
    nxt_ctrl.rsvd_lo  = '0;
  end

  // ---------------------------------------------------------------------------
  // wake context: event status and mask
  // ---------------------------------------------------------------------------
  // the mask and status form the wake context; without wake enable deepest
  // off discards them, so software must re-arm after the reset
  wire logic drop_ctx = is_cold && !ctrl_ff.wake_en;

  always_comb begin
    nxt_evmask = evmask_ff;
    nxt_evsts  = evsts_ff;
    if (wr_evmask) begin
      nxt_evmask = pwdata[BDPP_EV_W-1:0];
    end
    if (wr_evclr) begin
      nxt_evsts = nxt_evsts & ~pwdata[BDPP_EV_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_evsts = nxt_evsts | ev_now;
    if (drop_ctx) begin
      nxt_evsts  = BDPP_EV_RST;
      nxt_evmask = BDPP_EV_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= BDPP_ST_D0_UNINIT;
      ctrl_ff   <= BDPP_CTRL_RST;
      evsts_ff  <= BDPP_EV_RST;
      evmask_ff <= BDPP_EV_RST;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      evsts_ff  <= nxt_evsts;
      evmask_ff <= nxt_evmask;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt and wake signalling
  // ---------------------------------------------------------------------------
  wire logic ev_pending = |(evsts_ff & evmask_ff);

  // no interrupts in deepest off; the wake pin is the only way out
  assign irq       = ev_pending && !is_cold &&
                     state_ff == BDPP_ST_D0_ACTIVE;
  // open-drain wake pin only pulls low; only with wake enable set
  assign wake_n_o  = 1'b0;
  assign wake_n_oe = ev_pending && ctrl_ff.wake_en &&
                     state_ff != BDPP_ST_D0_ACTIVE;

  // ---------------------------------------------------------------------------
  // card clock and reset
  // ---------------------------------------------------------------------------
  // card clock is pclk/2 and runs only in full-on with the slot powered
  wire logic clk_run = (state_ff == BDPP_ST_D0_ACTIVE) &&
                       (ctrl_ff.slot_vcc != BDPP_VCC_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_div_ff <= 1'b0;
    end else begin
      clk_div_ff <= clk_run ? !clk_div_ff : 1'b0;
    end
  end

  assign card.clock    = clk_div_ff;
  // reset is released only in full-on, so it stays low in deepest off
  assign card.reset_n  = ctrl_ff.card_rst_rel && clk_run && !is_cold;
  assign card.slot_vcc = ctrl_ff.slot_vcc;

endmodule // bdpp_top

`default_nettype wire

// [verification/bdpp_card_model.sv]
// card side model: insertion, wake requests and low power reporting
`timescale 1ns/1ns
`default_nettype none
module bdpp_card_model
  import bdpp_pkg::*;
(
  input  wire logic       pclk,
  input  wire bdpp_card_t card,
  input  wire logic       insert,
  input  wire logic       wake_req,
  input  wire logic       sleep,
  output logic            card_present,
  output logic            card_wake,
  output logic            card_low_power
);
  initial begin
    card_present = 1'b0;
    card_wake = 1'b0;
  end
  // contacts move just after the edge, like a real card
  always @(posedge pclk) begin
    card_present <= insert;
    card_wake <= wake_req && insert;
  end
  // an absent or unpowered card counts as parked
  assign card_low_power = !card_present || sleep ||
                          card.slot_vcc == BDPP_VCC_OFF;
endmodule // bdpp_card_model
`default_nettype wire

// [verification/bdpp_sva.sv]
// checker: port-level properties of the bridge power policy
`timescale 1ns/1ns
`default_nettype none
module bdpp_sva
  import bdpp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        bus_seg_reset,
  input wire logic        main_power_lost,
  input wire logic        card_present,
  input wire logic        card_wake,
  input wire logic        card_low_power,
  input wire bdpp_card_t  card,
  input wire logic        wake_n_oe,
  input wire logic        irq
);
  // --------------------------------------------------------------------------
  // tracked power context
  // --------------------------------------------------------------------------
  logic cold_ff, hot_ff, wen_ff, msk_ff;
  wire  acc_wr  = psel && penable && pwrite && !cold_ff;
  wire  go_cold = hot_ff && main_power_lost && card_low_power;
  // only a segment reset clears cold, software cannot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cold_ff <= 1'b0;
      hot_ff  <= 1'b0;
      wen_ff  <= 1'b0;
      msk_ff  <= 1'b0;
    end else if (bus_seg_reset) begin
      cold_ff <= 1'b0;
      hot_ff  <= 1'b0;
    end else begin
      cold_ff <= cold_ff || go_cold;
      if (acc_wr && paddr == BDPP_CTRL_ADDR) begin
        hot_ff <= pwdata[17:16] == BDPP_PS_D3;
        wen_ff <= pwdata[8];
      end
      if (acc_wr && paddr == BDPP_EVMASK_ADDR) begin
        msk_ff <= pwdata[BDPP_EV_CARDWAKE];
      end
    end
  end
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence removal_s;
    $fell(card_present);
  endsequence
  sequence wake_ev_s;
    cold_ff && wen_ff && msk_ff && card_present ##0 $rose(card_wake);
  endsequence
  clk_stopped_a: assert property (cold_ff |-> !card.clock)
    else $error("card clock running in deepest off");
  rst_held_a: assert property (cold_ff |-> !card.reset_n)
    else $error("card reset released in deepest off");
  no_irq_a: assert property (cold_ff |-> !irq)
    else $error("interrupt in deepest off");
  wake_gate_a: assert property (cold_ff && !wen_ff |-> !wake_n_oe)
    else $error("wake without enable");
  wake_ctx_a: assert property (wake_ev_s |-> ##[1:3] wake_n_oe)
    else $error("wake not signalled in deepest off");
  vcc_keep_a: assert property (cold_ff && card_present &&
    $past(card_present) |-> $stable(card.slot_vcc))
    else $error("slot supply changed in deepest off");
  remove_off_a: assert property (removal_s |->
    ##[1:2] card.slot_vcc == BDPP_VCC_OFF)
    else $error("slot supply kept after removal");
  bus_mute_a: assert property (cold_ff && psel && penable && !pwrite
    |-> prdata == 32'h0)
    else $error("read answered in deepest off");
endmodule // bdpp_sva
`default_nettype wire

// [verification/bdpp_tb_top.sv]
// testbench: apb traffic, card events and the deepest off sequence
`timescale 1ns/1ns
`default_nettype none
module bdpp_tb_top
  import bdpp_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, m;
  logic        seg_rst, pwr_lost, ins, wreq, slp, err, irq;
  logic        card_present, card_wake, card_low_power, wake_n_o, wake_n_oe;
  logic [1:0]  v;
  bdpp_card_t  card;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  bdpp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_seg_reset(seg_rst), .main_power_lost(pwr_lost),
    .card_present(card_present), .card_wake(card_wake),
    .card_low_power(card_low_power), .card(card), .wake_n_o(wake_n_o),
    .wake_n_oe(wake_n_oe), .irq(irq));
  bdpp_card_model i_card (.pclk(pclk), .card(card), .insert(ins),
    .wake_req(wreq), .sleep(slp), .card_present(card_present),
    .card_wake(card_wake), .card_low_power(card_low_power));
  // --------------------------------------------------------------------------
  // clock, hang guard and helpers
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // the run needs about 150 cycles; far above that means a hang
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle cycle follows so psel is never set twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] ps, logic wen,
                                      logic [1:0] vcc);
    return {14'h0, ps, 7'h0, wen, 5'h0, vcc, 1'b1};
  endfunction
  // expected state word: code [2:0], slot powered [4], card present [5]
  function automatic logic [31:0] st_word(logic [2:0] st, logic pwr,
                                          logic pres);
    return {26'h0, pres, pwr, 1'b0, st};
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {seg_rst, pwr_lost, ins, wreq, slp, presetn} = '0;
    m = $urandom(32'h83e8);
    tick(8);
    presetn <= 1'b1;
    tick(1);
    // mask readback, unmapped place, move to active
    m = $urandom;
    apb(1'b1, BDPP_EVMASK_ADDR, m);
    apb(1'b0, BDPP_EVMASK_ADDR, 32'h0);
    chk(rd & 32'h7, m & 32'h7);
    chk(err, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D0, 1'b0, 2'h1));
    apb(1'b0, BDPP_STATE_ADDR, 32'h0);
    chk(rd[2:0], 3'h1);
    // light sleep state D1 keeps the slot setting against a software write
    apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D1, 1'b0, 2'h1));
    apb(1'b0, BDPP_STATE_ADDR, 32'h0);
    chk(rd, st_word(3'h2, 1'b1, 1'b0));
    apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D2, 1'b0, 2'h0));
    apb(1'b0, BDPP_STATE_ADDR, 32'h0);
    chk(rd, st_word(3'h3, 1'b1, 1'b0));
    chk(card.slot_vcc, 2'h1);
    apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D0, 1'b0, 2'h1));
    // insertion raises, masks and clears the interrupt
    apb(1'b1, BDPP_EVMASK_ADDR, 32'h2);
    ins <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    apb(1'b1, BDPP_EVMASK_ADDR, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, BDPP_EVCLR_ADDR, 32'h2);
    apb(1'b1, BDPP_EVMASK_ADDR, 32'h2);
    chk(irq, 1'b0);
    ins <= 1'b0;
    tick(4);
    chk(card.slot_vcc, BDPP_VCC_OFF);
    // deepest off, without and with wake enable
    for (int w = 0; w < 2; w++) begin
      seg_rst <= 1'b1;
      tick(2);
      seg_rst <= 1'b0;
      ins <= 1'b1;
      tick(4);
      v = 2'($urandom_range(3, 1));
      apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D0, w[0], v));
      apb(1'b1, BDPP_EVCLR_ADDR, 32'h7);
      apb(1'b1, BDPP_EVMASK_ADDR, 32'h7);
      apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D3, w[0], v));
      // a slot write while already asleep must not move the supply
      apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D3, w[0], ~v));
      chk(card.slot_vcc, v);
      slp <= 1'b1;
      pwr_lost <= 1'b1;
      tick(4);
      chk(card, {2'b00, v});
      chk(irq, 1'b0);
      apb(1'b0, BDPP_STATE_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, BDPP_CTRL_ADDR, ctl(BDPP_PS_D0, 1'b0, 2'h0));
      chk(card, {2'b00, v});
      wreq <= 1'b1;
      tick(4);
      chk(wake_n_oe, w[0]);
      chk(wake_n_o, 1'b0);
      wreq <= 1'b0;
      ins <= 1'b0;
      tick(4);
      chk(card.slot_vcc, BDPP_VCC_OFF);
      seg_rst <= 1'b1;
      tick(2);
      {seg_rst, pwr_lost, slp} <= 3'h0;
      tick(2);
      apb(1'b0, BDPP_STATE_ADDR, 32'h0);
      chk(rd[2:0], 3'h0);
    end
    complete_run();
  end
endmodule // bdpp_tb_top
bind bdpp_top bdpp_sva i_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .bus_seg_reset(bus_seg_reset),
  .main_power_lost(main_power_lost), .card_present(card_present),
  .card_wake(card_wake), .card_low_power(card_low_power), .card(card),
  .wake_n_oe(wake_n_oe), .irq(irq));
`default_nettype wire
